// File: src/wl_defs.vh
// Purpose: Constants for the write-leveling and clock-change device block
// Assumes: 100 MHz hclk, 32-bit AHB-Lite register access
// Notes: Offsets are byte addresses
`ifndef WL_DEFS_VH
`define WL_DEFS_VH
// ==========================================================
// Register offsets
`define OFS_MODE_ONE 8'h00
`define OFS_MODE_ZERO 8'h04
`define OFS_STATE 8'h08
`define OFS_CMD 8'h0c
// ==========================================================
// Field positions
`define MW1_LEVEL_BIT 7
`define MW1_QOFF_BIT 12
`define MW0_DLL_RESET_BIT 8
`define ST_LEVEL_BIT 0
`define ST_SELFREF_BIT 1
`define ST_PDOWN_BIT 2
`define ST_CLK_CARE_BIT 3
`define ST_SAMPLE_LO_BIT 4
`define ST_SAMPLE_HI_BIT 5
`define ST_DLL_LOCKED_BIT 6
`define CMD_SELFREF_BIT 0
`define CMD_PDOWN_BIT 1
// ==========================================================
// Reset values and timing
`define MW1_RESET 32'h0000_0000
`define MW0_RESET 32'h0000_0000
`define CLOCK_HOLD_CYC 16'h0005
`define DLL_LOCK_CYC 16'h0200
`define RESET_CLEAR_CYC 16'h0002
`endif

// File: src/strobe_sampler.v
// Purpose: Samples the link clock on a strobe rising edge for one byte lane
// Assumes: Strobe and link clock are already synchronised to hclk
// Notes: Resolution is one hclk period
`timescale 1ns/1ps
module strobe_sampler (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire enable,
  input wire strobe_s,
  input wire link_clk_s,
  output reg sample_r,
  output reg seen_r
);
  reg strobe_d_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_d_r <= 1'b0;
      sample_r <= 1'b0;
      seen_r <= 1'b0;
    end else if (ce) begin
      strobe_d_r <= strobe_s;
      if (!enable) begin
        seen_r <= 1'b0;
      end else if (strobe_s && !strobe_d_r) begin
        sample_r <= link_clk_s;
        seen_r <= 1'b1;
      end
    end
  end
endmodule // strobe_sampler

// File: src/wl_device.v
// Purpose: Device-side write leveling feedback and clock-change tracking
// Assumes: AHB-Lite single word transfers, controller keeps its own timing
// Notes: Pin inputs pass two flip-flops before use
`timescale 1ns/1ps
`include "wl_defs.vh"
module wl_device #(
  parameter WIDE = 1,
  parameter DLL_LOCK = 16'h0200
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire link_clk,
  input wire lower_byte_strobe,
  input wire upper_byte_strobe,
  input wire termination_control_pin,
  input wire clock_enable_pin,
  output reg [15:0] dq_out,
  output reg [15:0] dq_oe,
  output reg strobe_term_on
);
  // ==========================================================
  // Synchronisers
  // Pins are asynchronous to hclk; only the second stage is read
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (ce) begin
      sync1_r <= {clock_enable_pin, termination_control_pin, upper_byte_strobe,
                  lower_byte_strobe, link_clk};
      sync2_r <= sync1_r;
    end
  end
  wire clk_s = sync2_r[0];
  wire lstb_s = sync2_r[1];
  wire ustb_s = sync2_r[2];
  wire odt_s = sync2_r[3];
  wire cke_s = sync2_r[4];
  // ==========================================================
  // Registers
  reg [31:0] mode_one_r;
  reg [31:0] mode_zero_r;
  reg [1:0] cmd_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [15:0] lock_cnt_r;
  reg [15:0] hold_cnt_r;
  reg [1:0] rst_cnt_r;
  reg dll_locked_r;
  wire level_on = mode_one_r[`MW1_LEVEL_BIT];
  wire outs_off = mode_one_r[`MW1_QOFF_BIT];
  // Disabled outputs: the strobe is ignored and no line is driven
  wire sample_en = level_on && !outs_off;
  wire lo_sample;
  wire hi_sample;
  wire lo_seen;
  wire hi_seen;
  wire [1:0] lane_strobe = {ustb_s, lstb_s};
  wire [1:0] lane_en = {sample_en && (WIDE != 0), sample_en};
  wire [1:0] lane_sample;
  wire [1:0] lane_seen;
  // Only whole words are mapped; the transfer size is not decoded
  wire addr_ph = hsel && hready && htrans[1];
  wire low_power = cmd_r[`CMD_SELFREF_BIT] || (cmd_r[`CMD_PDOWN_BIT] && !cke_s);
  // Clock is a don't-care once the hold interval has run in low power
  wire clk_care = !(low_power && (hold_cnt_r == `CLOCK_HOLD_CYC));
  wire [31:0] state_word = {25'h0, dll_locked_r, hi_sample, lo_sample, clk_care,
                            cmd_r[`CMD_PDOWN_BIT], cmd_r[`CMD_SELFREF_BIT], level_on};
  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      mode_one_r <= `MW1_RESET;
      mode_zero_r <= `MW0_RESET;
      cmd_r <= 2'h0;
    end else if (ce) begin
      wr_pend_r <= addr_ph && hwrite;
      // Write address is held one cycle for the data phase
      wr_addr_r <= haddr[7:0];
      // Self-clear comes first so that a write in the same cycle wins
      if (mode_zero_r[`MW0_DLL_RESET_BIT] && {14'h0000, rst_cnt_r} == `RESET_CLEAR_CYC) begin
        mode_zero_r[`MW0_DLL_RESET_BIT] <= 1'b0;
      end
      if (wr_pend_r) begin
        case (wr_addr_r)
          `OFS_MODE_ONE: mode_one_r <= hwdata;
          `OFS_MODE_ZERO: mode_zero_r <= hwdata;
          `OFS_CMD: cmd_r <= hwdata[1:0];
          default: ;
        endcase
      end
      if (addr_ph && !hwrite) begin
        case (haddr[7:0])
          `OFS_MODE_ONE: hrdata <= mode_one_r;
          `OFS_MODE_ZERO: hrdata <= mode_zero_r;
          `OFS_STATE: hrdata <= state_word;
          `OFS_CMD: hrdata <= {30'h0, cmd_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ==========================================================
  // DLL reset and lock, clock-hold tracking
  // Lock time restarts on any reset; frequency change needs a fresh lock
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt_r <= 2'h0;
      lock_cnt_r <= 16'h0000;
      dll_locked_r <= 1'b0;
      hold_cnt_r <= 16'h0000;
    end else if (ce) begin
      // Reset bit self-clears after a short fixed count
      if (mode_zero_r[`MW0_DLL_RESET_BIT]) begin
        rst_cnt_r <= rst_cnt_r + 2'h1;
        lock_cnt_r <= 16'h0000;
        dll_locked_r <= 1'b0;
      end else begin
        rst_cnt_r <= 2'h0;
        if (!dll_locked_r && lock_cnt_r == DLL_LOCK - 16'h0001) begin
          dll_locked_r <= 1'b1;
        end else if (!dll_locked_r) begin
          lock_cnt_r <= lock_cnt_r + 16'h0001;
        end
      end
      if (!low_power) begin
        hold_cnt_r <= 16'h0000;
      end else if (hold_cnt_r != `CLOCK_HOLD_CYC) begin
        hold_cnt_r <= hold_cnt_r + 16'h0001;
      end
    end
  end
  // ==========================================================
  // Lane samplers
  // One sampler per byte lane; the upper lane idles on narrow parts
  // Resolution is one hclk period; nearer edges may sample either way
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
      strobe_sampler strobe_sampler_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .enable(lane_en[lane]),
        .strobe_s(lane_strobe[lane]),
        .link_clk_s(clk_s),
        .sample_r(lane_sample[lane]),
        .seen_r(lane_seen[lane])
      );
    end
  endgenerate
  assign lo_sample = lane_sample[0];
  assign hi_sample = lane_sample[1];
  assign lo_seen = lane_seen[0];
  assign hi_seen = lane_seen[1];
  // ==========================================================
  // Data line drive: prime lines report, others low
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_out <= 16'h0000;
      dq_oe <= 16'h0000;
      strobe_term_on <= 1'b0;
    end else if (ce) begin
      // Lines stay enabled while reporting; non-prime lines hold low
      dq_out <= 16'h0000;
      // A sample is shown only once a strobe edge has been seen
      dq_out[0] <= lo_seen && lo_sample;
      dq_out[8] <= (WIDE != 0) && hi_seen && hi_sample;
      if (sample_en) begin
        dq_oe <= (WIDE != 0) ? 16'hffff : 16'h00ff;
      end else begin
        dq_oe <= 16'h0000;
      end
      // Only strobe termination follows the pin, and only while leveling is on; data lines never terminate
      strobe_term_on <= level_on && odt_s;
    end
  end
endmodule // wl_device

// File: dv/wl_props.sv
// Purpose: Port checks for wl_device
// Assumes: WIDE=1, a few hclk of sync lag
// Notes: Sample checks need link_clk steady around the strobe edge
`timescale 1ns/1ps
// =====
module wl_props (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire link_clk,
  input wire lower_byte_strobe,
  input wire upper_byte_strobe,
  input wire termination_control_pin,
  input wire [15:0] dq_out,
  input wire [15:0] dq_oe,
  input wire strobe_term_on
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bad resp");
  property p_oe; dq_oe == 16'h0000 || dq_oe == 16'hffff; endproperty
  a_oe: assert property (p_oe) else $error("enables split");
  property p_lo7; dq_out[7:1] == 7'h00; endproperty
  a_lo7: assert property (p_lo7) else $error("low lines");
  property p_hi7; dq_out[15:9] == 7'h00; endproperty
  a_hi7: assert property (p_hi7) else $error("high lines");
  // Strobe termination is off once the pin has been low for five cycles
  property p_term; !termination_control_pin [*5] |-> !strobe_term_on; endproperty
  a_term: assert property (p_term) else $error("term on");
  property p_slo; $rose(lower_byte_strobe) && dq_oe[0] && link_clk && $past(link_clk)
    && $past(link_clk, 2) |-> ##[2:7] dq_out[0]; endproperty
  a_slo: assert property (p_slo) else $error("lower sample");
  property p_shi; $rose(upper_byte_strobe) && dq_oe[8] && link_clk && $past(link_clk)
    && $past(link_clk, 2) |-> ##[2:7] dq_out[8]; endproperty
  a_shi: assert property (p_shi) else $error("upper sample");
endmodule // wl_props
bind wl_device wl_props wl_props_inst (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .dq_out(dq_out),
  .lower_byte_strobe(lower_byte_strobe), .upper_byte_strobe(upper_byte_strobe),
  .termination_control_pin(termination_control_pin), .dq_oe(dq_oe),
  .strobe_term_on(strobe_term_on));

// File: dv/ctrl_model.sv
// Purpose: Controller stand-in: clock, strobes, termination, enable
// Assumes: 80 ns link clock, free running
// Notes: Strobes park low between toggles
`timescale 1ns/1ps
// =====
module ctrl_model (
  output reg link_clk,
  output reg lower_byte_strobe,
  output reg upper_byte_strobe,
  output reg termination_control_pin,
  output reg clock_enable_pin
);
  initial begin
    link_clk = 1'b0;
    lower_byte_strobe = 1'b0;
    upper_byte_strobe = 1'b0;
    termination_control_pin = 1'b0;
    clock_enable_pin = 1'b1;
  end
  always #40 link_clk = ~link_clk;
  // One toggle per delay setting; widths far above the minimum
  task toggle(input integer dly);
    begin
      @(posedge link_clk);
      #(dly);
      lower_byte_strobe = 1'b1;
      upper_byte_strobe = 1'b1;
      #30;
      lower_byte_strobe = 1'b0;
      upper_byte_strobe = 1'b0;
    end
  endtask
endmodule // ctrl_model

// File: dv/dram_write_leveling_clock_change_bench.sv
// Purpose: Self-checking bench for wl_device
// Assumes: DLL lock shortened to 16 cycles
// Notes: Link pins come from ctrl_model
`timescale 1ns/1ps
`include "wl_defs.vh"
// =====
module dram_write_leveling_clock_change_bench;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg ce = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [31:0] rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, link_clk, lbs, ubs, tcp, cke, term_on;
  wire [15:0] dq_out, dq_oe;
  integer error_cnt = 0;
  integer checks_done = 0;
  integer cyc = 0;
  always #5 hclk = ~hclk;
  wl_device #(.WIDE(1), .DLL_LOCK(16'h0010)) wl_device_inst (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link_clk(link_clk), .lower_byte_strobe(lbs), .upper_byte_strobe(ubs),
    .termination_control_pin(tcp), .clock_enable_pin(cke), .dq_out(dq_out),
    .dq_oe(dq_oe), .strobe_term_on(term_on));
  ctrl_model ctrl_model_inst (.link_clk(link_clk), .lower_byte_strobe(lbs),
    .upper_byte_strobe(ubs), .termination_control_pin(tcp), .clock_enable_pin(cke));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task t_regs;
    begin
      ce <= 1'b0;
      xfer(1'b1, `OFS_MODE_ONE, 32'h0000_0080);
      ce <= 1'b1;
      xfer(1'b0, `OFS_MODE_ONE, 32'h0);
      chk(rd, `MW1_RESET);
      xfer(1'b1, 32'h10, 32'hffff_ffff);
      xfer(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, `OFS_MODE_ZERO, 32'h0000_0105);
      repeat (6) @(posedge hclk);
      xfer(1'b0, `OFS_MODE_ZERO, 32'h0);
      chk(rd, 32'h0000_0005);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd & 32'h0000_0040, 32'h0);
    end
  endtask
  task t_level;
    begin
      repeat (20) @(posedge hclk);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd, 32'h0000_0048);
      ctrl_model_inst.termination_control_pin <= 1'b1;
      xfer(1'b1, `OFS_MODE_ONE, 32'h0000_0080);
      repeat (8) @(posedge hclk);
      chk({16'h0, dq_oe}, 32'h0000_ffff);
      chk({31'h0, term_on}, 32'h1);
      ctrl_model_inst.toggle(22);
      repeat (10) @(posedge hclk);
      chk({16'h0, dq_out}, 32'h0000_0101);
      ctrl_model_inst.toggle(62);
      repeat (10) @(posedge hclk);
      chk({16'h0, dq_out}, 32'h0);
      xfer(1'b1, `OFS_MODE_ONE, 32'h0000_1080);
      repeat (6) @(posedge hclk);
      chk({16'h0, dq_oe}, 32'h0);
      ctrl_model_inst.termination_control_pin <= 1'b0;
      xfer(1'b1, `OFS_MODE_ONE, 32'h0);
      repeat (8) @(posedge hclk);
      chk({15'h0, term_on, dq_oe}, 32'h0);
    end
  endtask
  task t_sref;
    begin
      ctrl_model_inst.clock_enable_pin <= 1'b0;
      xfer(1'b1, `OFS_CMD, 32'h1);
      repeat (12) @(posedge hclk);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd & 32'h0000_000a, 32'h0000_0002);
      xfer(1'b1, `OFS_CMD, 32'h0);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd & 32'h0000_000e, 32'h0000_0008);
    end
  endtask
  task t_pdown;
    begin
      ctrl_model_inst.termination_control_pin <= 1'b0;
      xfer(1'b1, `OFS_CMD, 32'h2);
      repeat (12) @(posedge hclk);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd & 32'h0000_000c, 32'h0000_0004);
      ctrl_model_inst.clock_enable_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd & 32'h0000_000c, 32'h0000_000c);
      xfer(1'b1, `OFS_CMD, 32'h0);
      xfer(1'b1, `OFS_MODE_ZERO, 32'h0000_0100);
      repeat (2) @(posedge hclk);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd & 32'h0000_0040, 32'h0);
      repeat (24) @(posedge hclk);
      xfer(1'b0, `OFS_STATE, 32'h0);
      chk(rd & 32'h0000_0040, 32'h0000_0040);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // A hang in any wait ends here rather than running forever
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_level;
    t_sref;
    t_pdown;
    wrap_up;
  end
endmodule // dram_write_leveling_clock_change_bench
